// ---- hw/asrc_pkg.sv ----
// package of pin groups, timing counts and states for the sram host controller
// Behaviour
// - both selects active with write strobe low stores enabled lanes at address
// - both selects active, strobe high, output enable low reads enabled lanes
// - host changes address no faster than one minimum read cycle; idle parks it at ADDR_RST and the next address can follow one cycle later
// - enable-driven read: data valid one select access delay after selects active
// - strobe-ended write: raise strobe with selects active, keep minimum pulse
// - select-ended write: drop a select after minimum pulse from write start; the host never does this, it always ends writes with the strobe
// - host waits strobe-to-float delay after lowering strobe before driving data
package asrc_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int CLK_NS = 50;
    // timing figures in ns; the device values are left to the integrator
    localparam int T_READ_CYCLE_NS = 100;
    localparam int T_ACCESS_NS = 100;
    localparam int T_WRITE_PULSE_NS = 100;
    localparam int T_STROBE_FLOAT_NS = 50;
    localparam int T_RELEASE_NS = 50;
    // least times round up, none below one cycle
    localparam int RD_CYC = ((T_ACCESS_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : ((T_ACCESS_NS + CLK_NS - 1) / CLK_NS);
    localparam int RC_CYC = ((T_READ_CYCLE_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1
        : ((T_READ_CYCLE_NS + CLK_NS - 1) / CLK_NS);
    localparam int WP_CYC = ((T_WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1
        : ((T_WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam int WZ_CYC = ((T_STROBE_FLOAT_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1
        : ((T_STROBE_FLOAT_NS + CLK_NS - 1) / CLK_NS);
    localparam int RL_CYC = ((T_RELEASE_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : ((T_RELEASE_NS + CLK_NS - 1) / CLK_NS);
    localparam int CNT_W = 8;
    localparam logic [1:0] LANES_NONE = 2'h3;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;

    // pins toward the memory, all active levels as on the part
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic chip_sel_low_active;
        logic chip_sel_high_active;
        logic write_n;
        logic out_en_n;
        logic lower_half_lane_en_n;
        logic upper_half_lane_en_n;
    } asrc_pins_t;

    // user request
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0] lanes_n;
    } asrc_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RD_WAIT = 3'h1,
        ST_RD_HOLD = 3'h2,
        ST_WR_FLOAT = 3'h3,
        ST_WR_PULSE = 3'h4,
        ST_RELEASE = 3'h5
    } asrc_state_t;
endpackage

// ---- hw/asrc_sync.sv ----
// three-stage input synchroniser; a change counts once stages two and three agree
`timescale 1ns/100ps
module asrc_sync
    import asrc_pkg::*;
#(
    parameter int W = 32
)(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } asrc_sync_st_t;

    asrc_sync_st_t st;
    asrc_sync_st_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // per-bit agreement filters a single settling glitch
        for (int i = 0; i < W; i++)
        begin
            if (st.s2[i] == st.s3[i])
            begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign dout = st.q;
endmodule

// ---- hw/asrc_host.sv ----
// host-side controller sequencing the pins of an asynchronous 128k x 32 memory
`timescale 1ns/100ps
module asrc_host
    import asrc_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic req_valid,
    output logic req_ready,
    input wire asrc_req_t req,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output asrc_pins_t pins,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic [DATA_W-1:0] dq_oe
);
    typedef struct packed {
        asrc_state_t fsm;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] since_addr;
        asrc_pins_t pins;
        logic [DATA_W-1:0] dq_out;
        logic [DATA_W-1:0] dq_oe;
        logic [DATA_W-1:0] rdata;
        logic rsp_valid;
    } asrc_host_st_t;

    localparam asrc_pins_t PINS_IDLE = '{addr: ADDR_RST, chip_sel_low_active: 1'b1,
        chip_sel_high_active: 1'b0, write_n: 1'b1, out_en_n: 1'b1,
        lower_half_lane_en_n: 1'b1, upper_half_lane_en_n: 1'b1};

    asrc_host_st_t st;
    asrc_host_st_t next_st;
    logic [DATA_W-1:0] dq_sync;

    // expands two lane enables to a per-bit mask, lower enable owns bits 15..0
    function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] lanes_n);
        lane_mask = {{HALF_W{~lanes_n[1]}}, {HALF_W{~lanes_n[0]}}};
    endfunction

    asrc_sync #(.W(DATA_W)) u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .din(dq_in),
        .dout(dq_sync)
    );

    // a new address only once a read cycle has passed since the last accepted request
    assign req_ready = (st.fsm == ST_IDLE) && (st.since_addr >= CNT_W'(RC_CYC));

    always_comb
    begin
        next_st = st;
        next_st.rsp_valid = 1'b0;
        if (st.since_addr != {CNT_W{1'b1}})
        begin
            next_st.since_addr = st.since_addr + CNT_W'(1);
        end
        unique case (st.fsm)
            ST_IDLE:
            begin
                // deselected while idle: device in standby, pins float
                next_st.pins = PINS_IDLE;
                if (req_valid && req_ready)
                begin
                    next_st.pins.addr = req.addr;
                    next_st.pins.chip_sel_low_active = 1'b0;
                    next_st.pins.chip_sel_high_active = 1'b1;
                    next_st.pins.lower_half_lane_en_n = req.lanes_n[0];
                    next_st.pins.upper_half_lane_en_n = req.lanes_n[1];
                    next_st.since_addr = '0;
                    next_st.cnt = '0;
                    if (req.write)
                    begin
                        // strobe first, our drivers stay off until the device floats
                        next_st.pins.write_n = 1'b0;
                        next_st.dq_out = req.wdata;
                        next_st.fsm = ST_WR_FLOAT;
                    end
                    else
                    begin
                        // our drivers are already off, so output enable may fall now
                        next_st.pins.out_en_n = 1'b0;
                        next_st.fsm = ST_RD_WAIT;
                    end
                end
            end
            ST_RD_WAIT:
            begin
                // selects, output enable and address all moved together: wait full access
                next_st.cnt = st.cnt + CNT_W'(1);
                if (st.cnt == CNT_W'(RD_CYC - 1))
                begin
                    next_st.fsm = ST_RD_HOLD;
                end
            end
            ST_RD_HOLD:
            begin
                // four edges in hold for the synchroniser before capture
                next_st.cnt = st.cnt + CNT_W'(1);
                if (st.cnt == CNT_W'(RD_CYC + 3))
                begin
                    next_st.rdata = dq_sync & lane_mask({st.pins.upper_half_lane_en_n,
                        st.pins.lower_half_lane_en_n});
                    next_st.rsp_valid = 1'b1;
                    next_st.pins.out_en_n = 1'b1;
                    next_st.cnt = '0;
                    next_st.fsm = ST_RELEASE;
                end
            end
            ST_WR_FLOAT:
            begin
                next_st.cnt = st.cnt + CNT_W'(1);
                if (st.cnt == CNT_W'(WZ_CYC - 1))
                begin
                    next_st.dq_oe = lane_mask(st.pins[1:0] == 2'h0 ? 2'h0
                        : {st.pins.upper_half_lane_en_n, st.pins.lower_half_lane_en_n});
                    next_st.cnt = '0;
                    next_st.fsm = ST_WR_PULSE;
                end
            end
            ST_WR_PULSE:
            begin
                // address held steady through the whole pulse
                next_st.cnt = st.cnt + CNT_W'(1);
                if (st.cnt == CNT_W'(WP_CYC - 1))
                begin
                    // strobe rises with both selects still active, data held this edge
                    next_st.pins.write_n = 1'b1;
                    next_st.cnt = '0;
                    next_st.fsm = ST_RELEASE;
                end
            end
            ST_RELEASE:
            begin
                // deselect and drop our drivers a cycle after the strobe for data hold
                next_st.dq_oe = '0;
                // selects outlast the strobe, so no write is ever ended by a deselect
                next_st.pins = PINS_IDLE;
                next_st.pins.addr = st.pins.addr;
                next_st.cnt = st.cnt + CNT_W'(1);
                if (st.cnt == CNT_W'(RL_CYC - 1))
                begin
                    next_st.fsm = ST_IDLE;
                end
            end
            default:
            begin
                next_st.fsm = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st.fsm <= ST_IDLE;
            st.cnt <= '0;
            st.since_addr <= {CNT_W{1'b1}};
            st.pins <= PINS_IDLE;
            st.dq_out <= DATA_RST;
            st.dq_oe <= '0;
            st.rdata <= DATA_RST;
            st.rsp_valid <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign pins = st.pins;
    assign dq_out = st.dq_out;
    assign dq_oe = st.dq_oe;
    assign rsp_valid = st.rsp_valid;
    assign rsp_rdata = st.rdata;

    // data may stand one edge past the strobe for hold; output enable stays high throughout
    a_no_contention: assert property (@(posedge core_clk) disable iff (srst)
        (st.dq_oe != '0) |-> (st.pins.out_en_n && (!st.pins.write_n || !$past(st.pins.write_n))))
        else $error("host drives data while device may drive");

    sequence s_wr_start;
        $fell(st.pins.write_n);
    endsequence
    a_write_float: assert property (@(posedge core_clk) disable iff (srst)
        s_wr_start |-> (st.dq_oe == '0) [*1])
        else $error("data driven before strobe-to-float delay");

    a_addr_stable: assert property (@(posedge core_clk) disable iff (srst)
        (!st.pins.write_n && !$past(st.pins.write_n)) |-> $stable(st.pins.addr))
        else $error("address moved during write pulse");

    a_strobe_end: assert property (@(posedge core_clk) disable iff (srst)
        $rose(st.pins.write_n) |-> (!st.pins.chip_sel_low_active && st.pins.chip_sel_high_active))
        else $error("write ended without selects active");

    a_rd_oe_off: assert property (@(posedge core_clk) disable iff (srst)
        $fell(st.pins.out_en_n) |-> (st.dq_oe == '0) && st.pins.write_n)
        else $error("output enable asserted with host drivers on");

    a_read_resp: assert property (@(posedge core_clk) disable iff (srst)
        $fell(st.pins.out_en_n) |-> ##[2:20] st.rsp_valid)
        else $error("read response missing");

    a_read_time: assert property (@(posedge core_clk) disable iff (srst)
        $fell(st.pins.out_en_n) |-> !st.rsp_valid [*2])
        else $error("read data captured before access delay");

    a_addr_rate: assert property (@(posedge core_clk) disable iff (srst)
        (req_valid && req_ready) |-> ##1 !req_ready)
        else $error("address accepted back to back");

    // lane, select and response pulse guards
    a_sel_hold: assert property (@(posedge core_clk) disable iff (srst)
        !st.pins.write_n |-> (!st.pins.chip_sel_low_active && st.pins.chip_sel_high_active))
        else $error("select dropped while strobe low");

    a_lane_float: assert property (@(posedge core_clk) disable iff (srst)
        (st.pins.lower_half_lane_en_n && st.pins.upper_half_lane_en_n) |-> (st.dq_oe == '0))
        else $error("data driven with both lanes disabled");

    a_rsp_pulse: assert property (@(posedge core_clk) disable iff (srst)
        st.rsp_valid |=> !st.rsp_valid)
        else $error("read response longer than one cycle");
endmodule

// ---- testbench/asrc_sram_model.sv ----
// behavioural model of the asynchronous 128k x 32 memory on the far side
`timescale 1ns/100ps
module asrc_sram_model
    import asrc_pkg::*;
#(
    parameter int DLY_NS = 40
)(
    input wire logic core_clk,
    input wire asrc_pins_t pins,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic [DATA_W-1:0] dq_oe,
    output logic [DATA_W-1:0] dq_in,
    output logic clash = 1'b0,
    output logic fault = 1'b0
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] noise = 32'hA5A5A5A5;
    logic [DATA_W-1:0] lane_m, rd_oe, rd_q, old;
    logic [ADDR_W-1:0] addr_prev = '0;
    logic sel, wr;
    logic sel_d = 1'b0;
    int wr_cnt = 0;
    int wr_len = 0;
    int age = 100;
    assign sel = !pins.chip_sel_low_active && pins.chip_sel_high_active;
    assign wr = sel && !pins.write_n;
    assign lane_m = {{HALF_W{!pins.upper_half_lane_en_n}}, {HALF_W{!pins.lower_half_lane_en_n}}};
    assign #(DLY_NS) rd_oe = (sel && pins.write_n && !pins.out_en_n) ? lane_m : '0;
    // undriven lines wander so a stale value never looks valid
    assign dq_in = (dq_oe & dq_out) | (~dq_oe & rd_oe & rd_q) | (~dq_oe & ~rd_oe & noise);
    always @(posedge core_clk) noise <= ~noise;
    always @(pins.addr or wr_cnt) rd_q <= #(DLY_NS) (mem.exists(pins.addr) ? mem[pins.addr] : ~noise);
    always @(negedge wr)
    begin
        old = mem.exists(pins.addr) ? mem[pins.addr] : '0;
        mem[pins.addr] = (old & ~lane_m) | (dq_in & lane_m);
        wr_cnt++;
    end
    always @(posedge core_clk)
    begin
        if (|(dq_oe & rd_oe)) clash <= 1'b1;
        wr_len <= wr ? wr_len + 1 : 0;
        if (!wr && wr_len != 0 && wr_len < WP_CYC) fault <= 1'b1;
        if (wr && wr_len != 0 && pins.addr != addr_prev) fault <= 1'b1;
        // an address that moves together with the selects starts an access, not a change
        if (sel && sel_d && pins.addr != addr_prev && age < RC_CYC - 1) fault <= 1'b1;
        sel_d <= sel;
        age <= (pins.addr != addr_prev) ? 0 : age + 1;
        addr_prev <= pins.addr;
    end
endmodule

// ---- testbench/async_sram_32bit_halfword_bench.sv ----
// self-checking bench for the sram host controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("Error %s expected %h seen %h", nm, e, g); end end
module async_sram_32bit_halfword_bench;
    import asrc_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    asrc_req_t req = '0;
    logic req_ready, rsp_valid, clash, fault;
    logic [DATA_W-1:0] rsp_rdata, dq_in, dq_out, dq_oe;
    asrc_pins_t pins;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    always #25 core_clk = ~core_clk;
    asrc_host i_dut (.core_clk(core_clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
    asrc_sram_model #(.DLY_NS(40)) i_mem (.core_clk(core_clk), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in), .clash(clash), .fault(fault));
    task automatic end_of_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            end_of_test();
        end
    end
    // returns just after the edge that took the request
    task automatic issue(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] ln);
        int n;
        n = 0;
        // let an edge pass so valid is never lowered and raised in one time step
        @(posedge core_clk);
        #1;
        req_valid = 1'b1;
        req = '{write: w, addr: a, wdata: d, lanes_n: ln};
        while (req_ready !== 1'b1 && n < 50)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK("ready_wait", 1'b1, req_ready)
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] ln, input logic [DATA_W-1:0] e);
        int n;
        n = 0;
        issue(1'b0, a, '0, ln);
        while (rsp_valid !== 1'b1 && n < 30)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK("rdata", e, rsp_rdata)
        `CHK("latency", RD_CYC + 4, n)
    endtask
    task automatic t_reset;
        `CHK("sel_low", 1'b1, pins.chip_sel_low_active)
        `CHK("sel_high", 1'b0, pins.chip_sel_high_active)
        `CHK("strobe", 1'b1, pins.write_n)
        `CHK("oe_n", 1'b1, pins.out_en_n)
        `CHK("oe", 32'h00000000, dq_oe)
    endtask
    task automatic t_word;
        issue(1'b1, 17'h00000, 32'h89ABCDEF, 2'h0);
        issue(1'b1, 17'h1FFFF, 32'h01234567, 2'h0);
        rd(17'h00000, 2'h0, 32'h89ABCDEF);
        rd(17'h1FFFF, 2'h0, 32'h01234567);
    endtask
    task automatic t_halves;
        issue(1'b1, 17'h00005, 32'h11112222, 2'h0);
        issue(1'b1, 17'h00005, 32'hAAAABBBB, 2'h2);
        @(posedge core_clk);
        #1;
        `CHK("half_oe", 32'h0000FFFF, dq_oe)
        `CHK("pulse", 1'b0, pins.write_n)
        rd(17'h00005, 2'h0, 32'h1111BBBB);
        issue(1'b1, 17'h00005, 32'hCCCCDDDD, 2'h1);
        rd(17'h00005, 2'h0, 32'hCCCCBBBB);
        rd(17'h00005, 2'h2, 32'h0000BBBB);
        rd(17'h00005, 2'h1, 32'hCCCC0000);
    endtask
    task automatic t_none;
        issue(1'b1, 17'h00005, 32'hFFFFFFFF, 2'h3);
        rd(17'h00005, 2'h0, 32'hCCCCBBBB);
        rd(17'h00005, 2'h3, 32'h00000000);
    endtask
    task automatic t_wire;
        `CHK("contention", 1'b0, clash)
        `CHK("timing", 1'b0, fault)
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk);
        #1;
        srst = 1'b0;
        @(posedge core_clk);
        #1;
        t_reset();
        t_word();
        t_halves();
        t_none();
        t_wire();
        end_of_test();
    end
endmodule
